// File: rtl/gcr_pkg.sv
// constants, types and timing for the glyph and cursor renderer
package gcr_pkg;

    // ****************************************************************
    // panel geometry
    // ****************************************************************
    localparam int          CHARS       = 20;
    localparam int          GLYPH_COLS  = 5;
    localparam int          SEG_COUNT   = 100;
    localparam int          COM_COUNT   = 16;
    localparam int          TEXT_DEPTH  = 128;
    localparam int          GLYPH_DEPTH = 64;
    localparam logic [4:0]  LAST_POS    = 5'h13;
    localparam logic [3:0]  LAST_ROW    = 4'hf;

    // ****************************************************************
    // addressing and glyph layout
    // ****************************************************************
    localparam logic [6:0]  LINE1_BASE  = 7'h00;
    localparam logic [6:0]  LINE2_BASE  = 7'h40;
    localparam logic [3:0]  USER_CODE_HI = 4'h0;
    localparam logic [3:0]  CURSOR_LINE_TALL  = 4'ha;
    localparam logic [3:0]  CURSOR_LINE_SHORT = 4'h7;
    localparam logic [4:0]  FULL_ROW    = 5'h1f;
    localparam logic [4:0]  ROWS_TWO    = 5'h10;
    localparam logic [4:0]  ROWS_TALL   = 5'h0b;
    localparam logic [4:0]  ROWS_SHORT  = 5'h08;
    localparam logic [15:0] COM_ONE     = 16'h0001;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int          CLOCK_HZ    = 40_000_000;
    localparam int          ROW_TIME_US = 625;
    localparam int          ROW_CYCLES  = (CLOCK_HZ / 1_000_000) * ROW_TIME_US;
    localparam logic [4:0]  BLINK_FRAMES = 5'h1f;

    typedef enum logic [2:0]
    {
        ST_WAIT,
        ST_TEXT,
        ST_GLYPH,
        ST_MERGE,
        ST_LATCH
    } gcr_state_t;

endpackage : gcr_pkg

// File: rtl/gcr_glyph_ram.sv
// user glyph ram: 64 lines of 5 pixels, host write port, display read port
`timescale 1ns/1ps
`default_nettype none
module gcr_glyph_ram
(
    // clock
    input  wire logic       i_clock,
    // host write port
    input  wire logic       i_wr_en,
    input  wire logic [5:0] i_wr_addr,
    input  wire logic [4:0] i_wr_data,
    // display read port
    input  wire logic [5:0] i_rd_addr,
    output logic      [4:0] o_rd_data
);

    logic [4:0] mem [gcr_pkg::GLYPH_DEPTH];

    // separate ports keep host writes away from refresh reads
    always_ff @(posedge i_clock)
    begin
        if (i_wr_en)
        begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem[i_rd_addr];
    end

endmodule : gcr_glyph_ram
`default_nettype wire

// File: rtl/gcr_glyph_cursor_render.sv
// glyph fetch, cursor and blink overlay and common/segment scan
//
// Contract
// - glyph row uses data bits 0..4, bit 4 is leftmost pixel
// - tall mode: code bits 1,2 form glyph ram address bits 4,5
// - bit one lights pixel, bit zero leaves it unselected
// - glyph ram address bits 0..3 select glyph line in tall mode, bits 0..2 otherwise
// - eleventh line shown as stored data ORed with cursor pattern
// - set eleventh line bits light regardless of cursor position
// - codes with bits 4..7 zero fetch from user glyph ram
// - tall mode ignores code bits 0 and 3
// - host access and refresh reads run on separate ports
// - sixteen common and one hundred segment outputs
// - only commons in use get selection, others stay off
// - cursor or blink at text address equal to cursor pointer
// - one-line: positions 1..20 map to addresses 00..13 hex
// - two-line: second line starts at address 40 hex
// - pointer into glyph ram may place cursor anywhere meaningless
`timescale 1ns/1ps
`default_nettype none
module gcr_glyph_cursor_render
#(
    parameter int ROW_CYCLES = gcr_pkg::ROW_CYCLES
)
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // host memory writes
    input  wire logic        i_host_wr,
    input  wire logic        i_host_to_glyph,
    input  wire logic [6:0]  i_host_addr,
    input  wire logic [7:0]  i_host_data,
    // display control
    input  wire logic [6:0]  i_cursor_pointer,
    input  wire logic        i_cursor_on,
    input  wire logic        i_blink_on,
    input  wire logic        i_two_line,
    input  wire logic        i_font_tall,
    // builtin glyph rom lookup
    output logic      [7:0]  o_rom_code,
    output logic      [3:0]  o_rom_line,
    input  wire logic [4:0]  i_rom_row,
    // panel drivers
    output logic      [15:0] o_common,
    output logic      [99:0] o_segment
);

    // ****************************************************************
    // text memory
    // ****************************************************************
    logic [7:0] text_mem [gcr_pkg::TEXT_DEPTH];
    logic [7:0] text_q;
    logic [6:0] text_rd_addr;

    always_ff @(posedge i_clock)
    begin
        if (i_host_wr && !i_host_to_glyph)
        begin
            text_mem[i_host_addr] <= i_host_data;
        end
        text_q <= text_mem[text_rd_addr];
    end

    // ****************************************************************
    // scan state
    // ****************************************************************
    gcr_pkg::gcr_state_t state_ff, nxt_state;
    logic [3:0]  row_ff,     nxt_row;
    logic [4:0]  pos_ff,     nxt_pos;
    logic [14:0] tick_ff,    nxt_tick;
    logic [4:0]  frame_ff,   nxt_frame;
    logic        blink_ff,   nxt_blink;
    logic [99:0] buf_ff,     nxt_buf;
    logic [15:0] common_ff,  nxt_common;
    logic [99:0] segment_ff, nxt_segment;
    logic [7:0]  rom_code_ff, nxt_rom_code;
    logic [3:0]  rom_line_ff, nxt_rom_line;
    logic        user_ff,    nxt_user;

    logic        tick;
    logic        tall;
    logic [3:0]  glyph_line;
    logic [6:0]  line_base;
    logic [5:0]  glyph_rd_addr;
    logic [4:0]  glyph_q;
    logic [4:0]  glyph_row;
    logic [4:0]  rows_used;
    logic [3:0]  cursor_line;
    logic        hit;
    logic [4:0]  pix;

    gcr_glyph_ram u_glyph_ram
    (
        .i_clock   (i_clock),
        .i_wr_en   (i_host_wr && i_host_to_glyph),
        .i_wr_addr (i_host_addr[5:0]),
        .i_wr_data (i_host_data[4:0]),
        .i_rd_addr (glyph_rd_addr),
        .o_rd_data (glyph_q)
    );

    // ****************************************************************
    // addressing and pixel merge
    // ****************************************************************
    always_comb
    begin
        tick       = (tick_ff == 15'(ROW_CYCLES - 1));
        tall       = i_font_tall && !i_two_line;
        glyph_line = i_two_line ? {1'b0, row_ff[2:0]} : row_ff;
        line_base  = (i_two_line && row_ff[3]) ? gcr_pkg::LINE2_BASE
                                               : gcr_pkg::LINE1_BASE;
        text_rd_addr = 7'(line_base + {2'b00, pos_ff});
        // tall glyphs drop code bits 0 and 3, so four codes share a glyph
        glyph_rd_addr = tall ? {text_q[2:1], glyph_line}
                             : {text_q[2:0], glyph_line[2:0]};
        rows_used     = i_two_line ? gcr_pkg::ROWS_TWO
                      : (tall ? gcr_pkg::ROWS_TALL : gcr_pkg::ROWS_SHORT);
        cursor_line = tall ? gcr_pkg::CURSOR_LINE_TALL
                           : gcr_pkg::CURSOR_LINE_SHORT;
        // a pointer into glyph ram simply matches some arbitrary cell
        hit = (text_rd_addr == i_cursor_pointer);
        glyph_row = user_ff ? glyph_q : i_rom_row;
        pix = glyph_row;
        if (hit && i_cursor_on && glyph_line == cursor_line)
        begin
            pix = pix | gcr_pkg::FULL_ROW;
        end
        if (hit && i_blink_on && blink_ff)
        begin
            pix = gcr_pkg::FULL_ROW;
        end
    end

    // ****************************************************************
    // scan sequencer
    // ****************************************************************
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_row      = row_ff;
        nxt_pos      = pos_ff;
        nxt_tick     = tick ? 15'h0000 : 15'(tick_ff + 15'h0001);
        nxt_frame    = frame_ff;
        nxt_blink    = blink_ff;
        nxt_buf      = buf_ff;
        nxt_common   = common_ff;
        nxt_segment  = segment_ff;
        nxt_rom_code = rom_code_ff;
        nxt_rom_line = rom_line_ff;
        nxt_user     = user_ff;
        case (state_ff)
            gcr_pkg::ST_WAIT:
            begin
                if (tick)
                begin
                    nxt_pos   = 5'h00;
                    nxt_state = gcr_pkg::ST_TEXT;
                end
            end
            gcr_pkg::ST_TEXT:
            begin
                nxt_state = gcr_pkg::ST_GLYPH;
            end
            gcr_pkg::ST_GLYPH:
            begin
                nxt_rom_code = text_q;
                nxt_rom_line = glyph_line;
                nxt_user     = (text_q[7:4] == gcr_pkg::USER_CODE_HI);
                nxt_state    = gcr_pkg::ST_MERGE;
            end
            gcr_pkg::ST_MERGE:
            begin
                // first character ends in the top bits, bit 4 leftmost
                nxt_buf = {buf_ff[94:0], pix};
                if (pos_ff == gcr_pkg::LAST_POS)
                begin
                    nxt_state = gcr_pkg::ST_LATCH;
                end
                else
                begin
                    nxt_pos   = 5'(pos_ff + 5'h01);
                    nxt_state = gcr_pkg::ST_TEXT;
                end
            end
            gcr_pkg::ST_LATCH:
            begin
                nxt_segment = buf_ff;
                // rows beyond the font and line count stay non-selected
                nxt_common = ({1'b0, row_ff} < rows_used)
                           ? 16'(gcr_pkg::COM_ONE << row_ff)
                           : 16'h0000;
                nxt_row = 4'(row_ff + 4'h1);
                if (row_ff == gcr_pkg::LAST_ROW)
                begin
                    nxt_frame = (frame_ff == gcr_pkg::BLINK_FRAMES)
                              ? 5'h00 : 5'(frame_ff + 5'h01);
                    nxt_blink = (frame_ff == gcr_pkg::BLINK_FRAMES)
                              ? !blink_ff : blink_ff;
                end
                nxt_state = gcr_pkg::ST_WAIT;
            end
            default:
            begin
                nxt_state = gcr_pkg::ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            state_ff    <= gcr_pkg::ST_WAIT;
            row_ff      <= 4'h0;
            pos_ff      <= 5'h00;
            tick_ff     <= 15'h0000;
            frame_ff    <= 5'h00;
            blink_ff    <= 1'b0;
            buf_ff      <= '0;
            common_ff   <= 16'h0000;
            segment_ff  <= '0;
            rom_code_ff <= 8'h00;
            rom_line_ff <= 4'h0;
            user_ff     <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            row_ff      <= nxt_row;
            pos_ff      <= nxt_pos;
            tick_ff     <= nxt_tick;
            frame_ff    <= nxt_frame;
            blink_ff    <= nxt_blink;
            buf_ff      <= nxt_buf;
            common_ff   <= nxt_common;
            segment_ff  <= nxt_segment;
            rom_code_ff <= nxt_rom_code;
            rom_line_ff <= nxt_rom_line;
            user_ff     <= nxt_user;
        end
    end

    assign o_common   = common_ff;
    assign o_segment  = segment_ff;
    assign o_rom_code = rom_code_ff;
    assign o_rom_line = rom_line_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb_scan @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    a_common_onehot: assert property ($onehot0(o_common))
        else $error("more than one common selected");
    a_unused_common: assert property (
        (state_ff == gcr_pkg::ST_LATCH && !i_two_line && !i_font_tall)
        |=> o_common[15:8] == 8'h00)
        else $error("unused common driven");
    a_user_select: assert property (
        state_ff == gcr_pkg::ST_GLYPH
        |=> user_ff == ($past(text_q[7:4]) == gcr_pkg::USER_CODE_HI))
        else $error("glyph source wrong");
    a_tall_addr: assert property (
        (state_ff == gcr_pkg::ST_GLYPH && tall)
        |-> glyph_rd_addr[5:4] == text_q[2:1]
            && glyph_rd_addr[3:0] == row_ff)
        else $error("tall glyph address wrong");
    a_cursor_or: assert property (
        (state_ff == gcr_pkg::ST_MERGE && hit && i_cursor_on
         && glyph_line == cursor_line)
        |=> buf_ff[4:0] == gcr_pkg::FULL_ROW)
        else $error("cursor line not lit");
    a_plain_pixels: assert property (
        (state_ff == gcr_pkg::ST_MERGE && !hit)
        |=> buf_ff[4:0] == $past(glyph_row))
        else $error("glyph row altered");
    a_text_addr: assert property (
        state_ff == gcr_pkg::ST_TEXT
        |-> text_rd_addr == 7'({2'b00, pos_ff}
            + ((i_two_line && row_ff[3]) ? 7'h40 : 7'h00)))
        else $error("text address mapping wrong");
    a_scan_steady: assert property (
        state_ff == gcr_pkg::ST_TEXT
        |=> state_ff == gcr_pkg::ST_GLYPH ##1 state_ff == gcr_pkg::ST_MERGE)
        else $error("refresh sequence disturbed");
    a_latch_seg: assert property (
        state_ff == gcr_pkg::ST_LATCH |=> o_segment == $past(buf_ff))
        else $error("segments not latched");

endmodule : gcr_glyph_cursor_render
`default_nettype wire

// File: verification/gcr_host_model.sv
// host and builtin glyph rom model on the far side of the renderer
`timescale 1ns/1ps
`default_nettype none
module gcr_host_model
(
    // clock
    input  wire logic       i_clock,
    // rom lookup
    input  wire logic [7:0] i_rom_code,
    input  wire logic [3:0] i_rom_line,
    output logic      [4:0] o_rom_row,
    // host writes
    output logic            o_host_wr,
    output logic            o_host_to_glyph,
    output logic      [6:0] o_host_addr,
    output logic      [7:0] o_host_data
);
    initial
    begin
        o_host_wr       = 1'b0;
        o_host_to_glyph = 1'b0;
        o_host_addr     = 7'h00;
        o_host_data     = 8'h00;
    end

    // stand-in font, any fixed function of code and line
    assign o_rom_row = i_rom_code[4:0] ^ {1'b0, i_rom_line};

    // strobe for one edge, then the released bus shows inverted values
    task automatic host_write(input logic to_glyph, input logic [6:0] addr,
                              input logic [7:0] data);
        @(posedge i_clock);
        o_host_wr       <= 1'b1;
        o_host_to_glyph <= to_glyph;
        o_host_addr     <= addr;
        o_host_data     <= data;
        @(posedge i_clock);
        o_host_wr       <= 1'b0;
        o_host_to_glyph <= ~to_glyph;
        o_host_addr     <= ~addr;
        o_host_data     <= ~data;
    endtask : host_write
endmodule : gcr_host_model
`default_nettype wire

// File: verification/tb_glyph_cursor_render.sv
// self-checking bench for the glyph and cursor renderer
`timescale 1ns/1ps
`default_nettype none
module tb_glyph_cursor_render;
    localparam int ROWS = 100;
    logic        i_clock = 1'b0;
    logic        i_rst_n;
    logic        wr, to_glyph, cur_on, blink, two, tall;
    logic [6:0]  addr, ptr;
    logic [7:0]  data, rom_code;
    logic [3:0]  rom_line;
    logic [4:0]  rom_row;
    logic [15:0] common;
    logic [99:0] segment;
    logic [7:0]  tm [128];
    logic [4:0]  gm [64];
    logic [7:0]  codes [8] = '{8'h00, 8'h01, 8'h08, 8'h09,
                               8'h02, 8'h04, 8'h06, 8'h0f};
    int          err_count = 0;
    int          compares = 0;

    always #12.5 i_clock = ~i_clock;

    gcr_glyph_cursor_render #(.ROW_CYCLES(ROWS)) dut
    (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_host_wr(wr),
        .i_host_to_glyph(to_glyph), .i_host_addr(addr), .i_host_data(data),
        .i_cursor_pointer(ptr), .i_cursor_on(cur_on), .i_blink_on(blink),
        .i_two_line(two), .i_font_tall(tall), .o_rom_code(rom_code),
        .o_rom_line(rom_line), .i_rom_row(rom_row), .o_common(common),
        .o_segment(segment)
    );

    gcr_host_model host
    (
        .i_clock(i_clock), .i_rom_code(rom_code), .i_rom_line(rom_line),
        .o_rom_row(rom_row), .o_host_wr(wr), .o_host_to_glyph(to_glyph),
        .o_host_addr(addr), .o_host_data(data)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [99:0] got, input logic [99:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    function automatic logic [99:0] exp_seg(input int row);
        logic [99:0] s;
        logic [7:0]  c;
        logic [6:0]  a;
        logic [3:0]  ln;
        logic [4:0]  px;
        logic        t;
        t = tall && !two;
        ln = two ? 4'(row % 8) : 4'(row);
        for (int i = 0; i < 20; i++)
        begin
            a = 7'(i) + ((two && row > 7) ? 7'h40 : 7'h00);
            c = tm[a];
            if (c[7:4] == 4'h0)
                px = gm[t ? {c[2:1], ln} : {c[2:0], ln[2:0]}];
            else
                px = c[4:0] ^ {1'b0, ln};
            if (cur_on && a == ptr && ln == (t ? 4'ha : 4'h7))
                px = px | 5'h1f;
            s[99 - 5 * i -: 5] = px;
        end
        return s;
    endfunction : exp_seg

    // one frame: every used row shown with its own common
    task automatic scan_frame(input int used);
        logic [15:0] seen;
        logic [15:0] last;
        int          r;
        seen = 16'h0000;
        last = common;
        repeat (1700)
        begin
            @(posedge i_clock);
            #1;
            if (common !== last && common !== 16'h0000)
            begin
                r = $clog2(common);
                seen[r] = 1'b1;
                check(100'($onehot(common)), 100'h1);
                check(segment, exp_seg(r));
            end
            last = common;
        end
        check(100'(seen), 100'(16'((32'h1 << used) - 1)));
        if (seen !== 16'((32'h1 << used) - 1))
            report_and_stop();
    endtask : scan_frame

    task automatic set_mode(input logic t, input logic w, input logic [6:0] p);
        @(posedge i_clock);
        tall <= t;
        two <= w;
        ptr <= p;
        cur_on <= 1'b1;
        repeat (1700) @(posedge i_clock);
    endtask : set_mode

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic run_reset;
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        #1;
        check(100'(common), 100'h0);
        check(segment, 100'h0);
    endtask : run_reset

    task automatic load_memories;
        logic [4:0] d;
        for (int a = 0; a < 64; a++)
        begin
            d = (a % 16 == 10) ? 5'h00 : 5'(a * 3 + 1);
            host.host_write(1'b1, 7'(a), {3'h5, d});
            gm[a] = d;
        end
        for (int p = 0; p < 20; p++)
        begin
            tm[p] = (p < 8) ? codes[p] : 8'(8'h20 + p);
            tm[p + 64] = (p < 8) ? codes[7 - p] : 8'(8'h40 + p);
            host.host_write(1'b0, 7'(p), tm[p]);
            host.host_write(1'b0, 7'(p + 64), tm[p + 64]);
        end
    endtask : load_memories

    task automatic check_tall;
        set_mode(1'b1, 1'b0, 7'h0e);
        fork
            scan_frame(11);
            repeat (300) host.host_write(1'b0, 7'h30, 8'h55);
        join
        tm[7'h30] = 8'h55;
    endtask : check_tall

    task automatic check_line11;
        host.host_write(1'b1, 7'h3a, 8'h11);
        gm[6'h3a] = 5'h11;
        set_mode(1'b1, 1'b0, 7'h0e);
        scan_frame(11);
    endtask : check_line11

    task automatic check_two_line;
        set_mode(1'b0, 1'b1, 7'h46);
        scan_frame(16);
    endtask : check_two_line

    // short one-line font: eight commons, cursor on line 7 of position 6
    task automatic check_short;
        set_mode(1'b0, 1'b0, 7'h05);
        scan_frame(8);
    endtask : check_short

    task automatic check_blink;
        int on_n;
        int off_n;
        on_n = 0;
        off_n = 0;
        @(posedge i_clock);
        blink <= 1'b1;
        repeat (70000)
        begin
            @(posedge i_clock);
            #1;
            // pointer 46h is line two, position 7, bits 69 down to 65
            if (common === 16'h4000 && segment[69 -: 5] === 5'h1f)
                on_n++;
            else if (common === 16'h4000)
            begin
                off_n++;
                check(100'(segment[69 -: 5]), 100'(gm[6'h0e]));
            end
        end
        check(100'(on_n > 0 && off_n > 0), 100'h1);
        @(posedge i_clock);
        blink <= 1'b0;
    endtask : check_blink

    initial
    begin
        i_rst_n = 1'b0;
        ptr = 7'h41;
        cur_on = 1'b0;
        blink = 1'b0;
        two = 1'b0;
        tall = 1'b0;
        run_reset();
        load_memories();
        check_tall();
        check_line11();
        check_short();
        check_two_line();
        check_blink();
        report_and_stop();
    end
endmodule : tb_glyph_cursor_render
`default_nettype wire
